// *** inc/wcap_defs.vh ***
// Purpose: Shared constants for the write port capture block
// Assumes: Included by bare name from rtl files
// Notes:   Word width selects lane count and address width
`ifndef WCAP_DEFS_VH
`define WCAP_DEFS_VH
`define WCAP_LANE_W      9
`define WCAP_WORD_W_X18  18
`define WCAP_WORD_W_X36  36
`define WCAP_ADDR_W_X18  21
`define WCAP_ADDR_W_X36  20
`define WCAP_BEATS       4
`define WCAP_FIFO_DEPTH  8
`endif

// *** rtl/sram_write_port_capture.v ***
// Purpose: Input capture for the write port and shared address of a DDR burst SRAM
// Assumes: Both clock edges arrive as one-cycle enables on clock_i
// Notes:   Captured bursts queue in a FIFO toward the array writer
//
// Summary of operation
// - Write data is captured on both true and complementary clock rising edges.
// - Active-low write select sampled on true edge starts a write when no burst is in progress.
// - Write select high deselects the port; data bus is ignored.
// - Lane masks sampled on both edges; only unmasked lanes are stored.
// - Each 9-bit lane has its own mask, mask 0 on bits 8..0.
// - Mask and data captured together on the same edge.
// - Shared address sampled on true edge for any active read, and for a write only when no burst is in progress.
// - Address is 21 bits for 18-bit words, 20 bits for 36-bit.
// - Address ignored for a deselected port; no access starts.
// - Accesses start only on true clock edges, never complementary.
// - Active-low read select on true edge starts a four-beat read burst.
`timescale 1ns/1ps
`include "wcap_defs.vh"
module sram_write_port_capture #(
  parameter WORD_W = `WCAP_WORD_W_X36,
  parameter LANES  = WORD_W / `WCAP_LANE_W,
  parameter ADDR_W = (WORD_W == `WCAP_WORD_W_X18) ? `WCAP_ADDR_W_X18 : `WCAP_ADDR_W_X36,
  parameter DEPTH  = `WCAP_FIFO_DEPTH
) (
  input  wire                          clock_i,
  input  wire                          nrst_i,
  input  wire                          true_edge_i,
  input  wire                          comp_edge_i,
  input  wire                          write_port_sel_n_i,
  input  wire                          read_port_pick_n_i,
  input  wire [ADDR_W-1:0]             addr_i,
  input  wire [WORD_W-1:0]             wdata_i,
  input  wire [LANES-1:0]              lane_write_mask_n_i,
  output wire                          wr_valid_o,
  input  wire                          wr_ready_i,
  output wire [ADDR_W-1:0]             wr_addr_o,
  output wire [4*WORD_W-1:0]           wr_data_o,
  output wire [4*LANES-1:0]            wr_lane_en_o,
  output reg                           rd_start_o,
  output reg  [ADDR_W-1:0]             rd_addr_o,
  output wire                          cap_ready_o,
  output reg                           overrun_o
);
  localparam PKT_W = ADDR_W + 4 * WORD_W + 4 * LANES;
  // Phase code doubles as the beat index of the edge it waits for
  localparam [1:0] PH_IDLE  = 2'h0;
  localparam [1:0] PH_FALL0 = 2'h1;
  localparam [1:0] PH_RISE1 = 2'h2;
  localparam [1:0] PH_FALL1 = 2'h3;

  // Pointer width follows the queue depth, so a deeper queue needs no edit
  function integer ptr_bits;
    input integer depth;
    integer v;
    begin
      ptr_bits = 1;
      v        = 2;
      while (v < depth) begin
        ptr_bits = ptr_bits + 1;
        v        = v * 2;
      end
    end
  endfunction

  localparam FIFO_AW = ptr_bits(DEPTH);

  reg [1:0]           phase_r;
  reg [1:0]           phase_nxt;
  reg [ADDR_W-1:0]    waddr_r;
  reg [4*WORD_W-1:0]  wbuf_r;
  reg [4*LANES-1:0]   wen_r;
  reg                 push_r;
  wire                fifo_in_ready;
  wire [PKT_W-1:0]    fifo_out;
  wire                beat_edge;
  wire [1:0]          beat_idx;
  wire                write_start;
  wire                read_start;
  wire                step_due;
  wire [PKT_W-1:0]    fifo_in;

  // Merge data with stored word: masked lanes keep the old content
  function [WORD_W-1:0] lane_merge;
    input [WORD_W-1:0] old_w;
    input [WORD_W-1:0] new_w;
    input [LANES-1:0]  en;
    integer k;
    begin
      lane_merge = old_w;
      for (k = 0; k < LANES; k = k + 1) begin
        if (en[k]) begin
          lane_merge[k*`WCAP_LANE_W +: `WCAP_LANE_W] =
            new_w[k*`WCAP_LANE_W +: `WCAP_LANE_W];
        end
      end
    end
  endfunction

  // A select only counts on a true edge; both ports share this decode
  function port_req;
    input tick;
    input sel_n;
    begin
      port_req = tick & ~sel_n;
    end
  endfunction

  // Edge the current phase waits for; idle waits for a true edge
  function beat_due;
    input [1:0] ph;
    input       te;
    input       ce;
    begin
      case (ph)
        PH_FALL0: beat_due = ce;
        PH_RISE1: beat_due = te;
        PH_FALL1: beat_due = ce;
        default:  beat_due = te;
      endcase
    end
  endfunction

  // Start only on a true edge with select low and no burst in flight
  assign write_start = port_req(true_edge_i, write_port_sel_n_i)
                       && (phase_r == PH_IDLE);
  assign read_start  = port_req(true_edge_i, read_port_pick_n_i);
  assign step_due    = beat_due(phase_r, true_edge_i, comp_edge_i);
  assign beat_idx    = (phase_r == PH_IDLE) ? 2'h0 : phase_r;
  assign beat_edge   = write_start
                       || ((phase_r != PH_IDLE) && step_due);
  // Controller sees back-pressure one cycle after the push that fills the queue, too late for a back-to-back burst
  assign cap_ready_o = fifo_in_ready;

  always @* begin
    phase_nxt = phase_r;
    case (phase_r)
      PH_IDLE: begin
        if (write_start)
          phase_nxt = PH_FALL0;
      end
      PH_FALL0: begin
        if (step_due)
          phase_nxt = PH_RISE1;
      end
      PH_RISE1: begin
        if (step_due)
          phase_nxt = PH_FALL1;
      end
      PH_FALL1: begin
        if (step_due)
          phase_nxt = PH_IDLE;
      end
      default: begin
        phase_nxt = PH_IDLE;
      end
    endcase
  end

  // Burst phase and the one-cycle push toward the queue
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      phase_r <= PH_IDLE;
      push_r  <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      push_r  <= (phase_r == PH_FALL1) && step_due;
    end
  end

  // Address and beats; the buffer keeps masked lanes of the last burst
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      waddr_r <= {ADDR_W{1'b0}};
      wbuf_r  <= {(4*WORD_W){1'b0}};
      wen_r   <= {(4*LANES){1'b0}};
    end else begin
      if (write_start)
        waddr_r <= addr_i;
      if (beat_edge) begin
        // Mask and data taken on the same edge
        wbuf_r[beat_idx*WORD_W +: WORD_W] <= lane_merge(
          wbuf_r[beat_idx*WORD_W +: WORD_W], wdata_i, ~lane_write_mask_n_i);
        wen_r[beat_idx*LANES +: LANES] <= ~lane_write_mask_n_i;
      end
    end
  end

  // Burst is dropped if the queue is full; flag stays until reset
  always @(posedge clock_i) begin
    if (!nrst_i)
      overrun_o <= 1'b0;
    else if (push_r && !fifo_in_ready)
      overrun_o <= 1'b1;
  end

  // Read start on true edge only, address ignored when deselected
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      rd_start_o <= 1'b0;
      rd_addr_o  <= {ADDR_W{1'b0}};
    end else begin
      rd_start_o <= read_start;
      if (read_start)
        rd_addr_o <= addr_i;
    end
  end

  wcap_fifo #(
    .WIDTH (PKT_W),
    .DEPTH (DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clock_i     (clock_i),
    .nrst_i      (nrst_i),
    .in_data_i   (fifo_in),
    .in_valid_i  (push_r),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i)
  );

  // Queue word: address on top, then four beats, lane enables at the bottom
  assign fifo_in      = {waddr_r, wbuf_r, wen_r};
  assign wr_addr_o    = fifo_out[PKT_W-1 -: ADDR_W];
  assign wr_data_o    = fifo_out[4*LANES +: 4*WORD_W];
  assign wr_lane_en_o = fifo_out[4*LANES-1:0];
endmodule // sram_write_port_capture

// *** rtl/wcap_fifo.v ***
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-low reset
// Notes:   Full and empty come from a count, no bypass path
`timescale 1ns/1ps
module wcap_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clock_i,
  input  wire             nrst_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;

  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      if (p == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1})
        ptr_inc = {AW{1'b0}};
      else
        ptr_inc = p + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  assign in_ready_o  = (count_r != DEPTH[AW:0]);
  assign out_valid_o = (count_r != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clock_i) begin
    if (push)
      mem[wr_ptr_r] <= in_data_i;
  end

  always @(posedge clock_i) begin
    if (!nrst_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      if (pop)
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      if (push && !pop)
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      else if (pop && !push)
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // wcap_fifo

// *** sim/ctrl_edge_model.sv ***
// Purpose: Controller input clock model
// Assumes: Clock runs free once reset lifts
// Notes:   True edge first, then alternating
`timescale 1ns/1ps
module ctrl_edge_model (
  input  wire clock_i,
  input  wire nrst_i,
  output reg  true_edge_o,
  output reg  comp_edge_o
);
  always @(posedge clock_i) begin
    true_edge_o <= nrst_i & ~true_edge_o;
    comp_edge_o <= nrst_i & true_edge_o;
  end
endmodule // ctrl_edge_model

// *** sim/swpc_asserts.sv ***
// Purpose: Port checks for capture block
// Assumes: Edge enables on clock_i
// Notes:   Lane data judged by the bench
`timescale 1ns/1ps
module swpc_asserts #(parameter WORD_W = 36, parameter ADDR_W = 20) (
  input wire                clock_i, nrst_i, true_edge_i, write_port_sel_n_i,
  input wire                read_port_pick_n_i, wr_valid_o, wr_ready_i, rd_start_o,
  input wire                cap_ready_o,
  input wire [ADDR_W-1:0]   addr_i, wr_addr_o, rd_addr_o,
  input wire [4*WORD_W-1:0] wr_data_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence rd_req; true_edge_i && !read_port_pick_n_i; endsequence
  sequence wr_req; true_edge_i && !write_port_sel_n_i && cap_ready_o; endsequence
  rd_start_pulse_a:
    assert property (rd_req |=> rd_start_o) else $error("no read start");
  rd_addr_take_a:
    assert property (rd_req |=> rd_addr_o == $past(addr_i)) else $error("bad read addr");
  rd_cause_a:
    assert property (rd_start_o |-> $past(true_edge_i && !read_port_pick_n_i))
      else $error("read uncaused");
  rd_no_start_a:
    assert property (!(true_edge_i && !read_port_pick_n_i) |=> !rd_start_o) else $error("stray read");
  wr_burst_done_a:
    assert property (wr_req ##1 !wr_ready_i [*4] |=> wr_valid_o) else $error("burst lost");
  wr_hold_a:
    assert property (wr_valid_o && !wr_ready_i |=> $stable(wr_addr_o) && $stable(wr_data_o))
      else $error("burst changed");
  wr_quiet_a:
    assert property ((!wr_valid_o && !(true_edge_i && !write_port_sel_n_i)) [*6] |=> !wr_valid_o)
      else $error("stray burst");
  reset_state_a: // Idle outputs in reset
    assert property (disable iff (1'b0) !nrst_i |=> !wr_valid_o && !rd_start_o && cap_ready_o)
      else $error("not idle in reset");
endmodule // swpc_asserts
bind sram_write_port_capture swpc_asserts #(.WORD_W(WORD_W), .ADDR_W(ADDR_W)) chk (
  .clock_i(clock_i), .nrst_i(nrst_i), .true_edge_i(true_edge_i), .addr_i(addr_i),
  .write_port_sel_n_i(write_port_sel_n_i), .read_port_pick_n_i(read_port_pick_n_i),
  .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .rd_start_o(rd_start_o),
  .cap_ready_o(cap_ready_o), .wr_addr_o(wr_addr_o), .rd_addr_o(rd_addr_o),
  .wr_data_o(wr_data_o));

// *** sim/tb_sram_write_port_capture.sv ***
// Purpose: Bench for bursts, reads, FIFO fill
// Assumes: 36-bit words, 4 lanes, 20-bit address
// Notes:   Masked lanes hold stale data, not compared
`timescale 1ns/1ps
module tb_sram_write_port_capture;
  reg          clk = 0, nrst = 0, sel_n = 1, pick_n = 1, rdy = 0;
  reg  [19:0]  addr = 0, qa [0:7];
  reg  [35:0]  wd = 0;
  reg  [3:0]   mk = 4'hF;
  reg  [143:0] qd [0:7];
  reg  [15:0]  qe [0:7];
  wire         te, ce, wv, rs, cr, ov;
  wire [19:0]  wa, ra;
  wire [143:0] wdo;
  wire [15:0]  we;
  integer      err_count = 0, checks_done = 0, n, j;
  ctrl_edge_model PM (.clock_i(clk), .nrst_i(nrst), .true_edge_o(te), .comp_edge_o(ce));
  sram_write_port_capture DUT (.clock_i(clk), .nrst_i(nrst), .true_edge_i(te), .comp_edge_i(ce),
    .write_port_sel_n_i(sel_n), .read_port_pick_n_i(pick_n), .addr_i(addr), .wdata_i(wd),
    .lane_write_mask_n_i(mk), .wr_valid_o(wv), .wr_ready_i(rdy), .wr_addr_o(wa), .wr_data_o(wdo),
    .wr_lane_en_o(we), .rd_start_o(rs), .rd_addr_o(ra), .cap_ready_o(cr), .overrun_o(ov));
  task check(input [143:0] seen, input [143:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) err_count = err_count + 1;
      if (seen !== exp) $display("Error at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  function [143:0] keep(input [15:0] en);
    integer k;
    for (k = 0; k < 16; k = k + 1) keep[k*9 +: 9] = {9{en[k]}};
  endfunction
  task burst(input s, input integer slot);
    integer b;
    reg [63:0] dm;
    reg [19:0] a;
    reg        pk;
    begin
      do @(posedge clk); while (ce !== 1'b1);
      for (b = 0; b < 4; b = b + 1) begin
        if (b > 0) @(posedge clk);
        if (b == 2) check(rs ? ra : 21'h100000, pk ? 21'h100000 : a);
        if (b == 3) check(rs, 1'b0);
        dm = {$urandom, $urandom};
        if (b == 0) a = dm[63:44];
        if (b == 0) pk = dm[40];
        sel_n <= b == 0 ? s : (b == 2 ? s | dm[41] : 1'b1);
        pick_n <= b[0] ? 1'b0 : (b == 0 ? dm[40] : 1'b1);
        addr <= dm[63:44];
        wd <= dm[39:4];
        mk <= dm[3:0];
        if (!s && slot < 8) qa[slot] = a;
        if (!s && slot < 8) qd[slot][b*36 +: 36] = dm[39:4];
        if (!s && slot < 8) qe[slot][b*4 +: 4] = ~dm[3:0];
      end
    end
  endtask
  task drain(input integer cnt);
    integer i, w;
    for (i = 0; i < cnt; i = i + 1) begin
      for (w = 0; w < 20 && wv !== 1'b1; w = w + 1) @(posedge clk);
      check({we, wa}, {qe[i], qa[i]});
      check(wdo & keep(qe[i]), qd[i] & keep(qe[i]));
      rdy <= 1;
      @(posedge clk);
      rdy <= 0;
      repeat (2) @(posedge clk);
    end
  endtask
  task tally_and_finish;
    begin
      $display("Checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    #20000 err_count = err_count + 1;
    tally_and_finish;
  end
  initial begin
    j = $urandom(32'h2D400FB3);
    repeat (8) @(posedge clk);
    nrst <= 1;
    for (n = 0; n < 9; n = n + 1) burst(0, n);
    repeat (8) @(posedge clk);
    check({cr, ov, wv}, 3'h3);
    drain(8);
    burst(1, 8);
    repeat (10) @(posedge clk);
    check({cr, wv}, 2'h2);
    burst(0, 0);
    drain(1);
    tally_and_finish;
  end
endmodule // tb_sram_write_port_capture
